// ### logic/fgtrim_bank.sv
/*
 * fine gain trim register bank: seven byte registers, fuse preload,
 * mode-steered trim outputs to the four sub-converter banks.
 * assumes the serial register port front end delivers decoded byte
 * accesses on clk, and the fuse reader presents one trim per cycle.
 * reset is synchronous and active low; the mode input and the fuse strobe
 * come from logic on clk, so they pass no synchroniser.
 */
`timescale 1ns/1ps

// Operation
// R01: in two-channel mode the a1, b0 and b1 trims come from offsets 351h, 352h and 353h.
// R02: in one-channel mode the a0, a1, b0 and b1 trims come from offsets 354h to 357h.
// R03: each register keeps the gain in bits 4:0 and writable reserved bits 7:5 that reset to zero.
// R04: the two-channel gain fields are preloaded with factory values from fuse memory.
// R05: the one-channel gain fields are preloaded from fuse memory on their own.
// R06: every trim register resets to zero, whole byte and gain field alike.
// R07: a software write updates that register and a later read returns the written value.
module fgtrim_bank (
   input wire logic clk,
   input wire logic rstn,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [fgtrim_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [fgtrim_pkg::DATA_W-1:0] reg_wdata,
   output logic [fgtrim_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic fuse_valid,
   input wire logic [fgtrim_pkg::IDX_W-1:0] fuse_index,
   input wire logic [fgtrim_pkg::TRIM_W-1:0] fuse_trim,
   input wire logic one_channel_mode,
   input wire logic [fgtrim_pkg::TRIM_W-1:0] trim_a_bank0_two_channel,
   output logic [fgtrim_pkg::TRIM_W-1:0] trim_a_bank0,
   output logic [fgtrim_pkg::TRIM_W-1:0] trim_a_bank1,
   output logic [fgtrim_pkg::TRIM_W-1:0] trim_b_bank0,
   output logic [fgtrim_pkg::TRIM_W-1:0] trim_b_bank1
);
   import fgtrim_pkg::*;

   // ==========================================================
   // elaboration checks, the index and field layout must fit the bank
   if (NUM_REGS > (1 << IDX_W)) begin : g_chk_idx_w
      $error("register index too narrow for the bank");
   end
   if (GAIN_MSB - GAIN_LSB + 1 != TRIM_W) begin : g_chk_gain_w
      $error("gain field width differs from the trim width");
   end
   if (RSVD_MSB + 1 != DATA_W || RSVD_LSB != GAIN_MSB + 1) begin : g_chk_rsvd
      $error("reserved field does not fill the byte above the gain");
   end

   // ==========================================================
   // state
   typedef struct packed {
      logic [NUM_REGS-1:0][DATA_W-1:0] regs;
      logic [DATA_W-1:0] rdata;
      logic rvalid;
      logic one_mode;
      logic [TRIM_W-1:0] a0;
      logic [TRIM_W-1:0] a1;
      logic [TRIM_W-1:0] b0;
      logic [TRIM_W-1:0] b1;
   } fgtrim_state_t;

   fgtrim_state_t state_q;
   fgtrim_state_t state_d;

   // address decode, shared by the read and the write path
   function automatic logic [IDX_W:0] fgtrim_decode(input logic [ADDR_W-1:0] addr);
      logic [IDX_W:0] res;
      res = '0;
      case (addr)
         OFS_A1_TWO: res = {1'b1, IDX_A1_TWO};
         OFS_B0_TWO: res = {1'b1, IDX_B0_TWO};
         OFS_B1_TWO: res = {1'b1, IDX_B1_TWO};
         OFS_A0_ONE: res = {1'b1, IDX_A0_ONE};
         OFS_A1_ONE: res = {1'b1, IDX_A1_ONE};
         OFS_B0_ONE: res = {1'b1, IDX_B0_ONE};
         OFS_B1_ONE: res = {1'b1, IDX_B1_ONE};
         default: res = '0;
      endcase
      return res;
   endfunction

   // decode results and the fuse index guard
   logic [IDX_W:0] dec;
   logic hit;
   logic [IDX_W-1:0] idx;
   logic fuse_ok;

   // split the decode into hit flag and register index
   assign dec = fgtrim_decode(reg_addr);
   assign hit = dec[IDX_W];
   assign idx = dec[IDX_W-1:0];
   assign fuse_ok = fuse_valid && (fuse_index < IDX_W'(NUM_REGS));

   // ==========================================================
   // next state
   always_comb begin
      state_d = state_q;
      state_d.rvalid = reg_rd_en;
      state_d.rdata = UNMAPPED_READ;
      // R07: read back
      if (reg_rd_en && hit) begin
         state_d.rdata = state_q.regs[idx];
      end
      // R07: software write
      // R03: whole byte stored
      if (reg_wr_en && hit) begin
         state_d.regs[idx] = reg_wdata;
      end
      // R04: two-channel fuse preload
      // R05: one-channel fuse preload, fuse wins a clash
      if (fuse_ok) begin
         state_d.regs[fuse_index] = {RSVD_RESET, fuse_trim};
      end
      state_d.one_mode = one_channel_mode;
      // R02: one-channel set steers all four banks
      if (one_channel_mode) begin
         state_d.a0 = state_d.regs[IDX_A0_ONE][GAIN_MSB:GAIN_LSB];
         state_d.a1 = state_d.regs[IDX_A1_ONE][GAIN_MSB:GAIN_LSB];
         state_d.b0 = state_d.regs[IDX_B0_ONE][GAIN_MSB:GAIN_LSB];
         state_d.b1 = state_d.regs[IDX_B1_ONE][GAIN_MSB:GAIN_LSB];
      end else begin
         // R01: two-channel set, a0 kept by its own register elsewhere
         state_d.a0 = trim_a_bank0_two_channel;
         state_d.a1 = state_d.regs[IDX_A1_TWO][GAIN_MSB:GAIN_LSB];
         state_d.b0 = state_d.regs[IDX_B0_TWO][GAIN_MSB:GAIN_LSB];
         state_d.b1 = state_d.regs[IDX_B1_TWO][GAIN_MSB:GAIN_LSB];
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk) begin
      // R06: all registers clear to zero
      if (!rstn) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   // outputs straight from the state register
   assign reg_rdata = state_q.rdata;
   assign reg_rvalid = state_q.rvalid;
   assign trim_a_bank0 = state_q.a0;
   assign trim_a_bank1 = state_q.a1;
   assign trim_b_bank0 = state_q.b0;
   assign trim_b_bank1 = state_q.b1;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // output mapping against the stored registers and the two-channel a0 input
   chk_two_mode_map: assert property ( // R01
      !state_q.one_mode |-> (trim_a_bank1 == state_q.regs[IDX_A1_TWO][GAIN_MSB:GAIN_LSB]
         && trim_b_bank0 == state_q.regs[IDX_B0_TWO][GAIN_MSB:GAIN_LSB]
         && trim_b_bank1 == state_q.regs[IDX_B1_TWO][GAIN_MSB:GAIN_LSB]))
      else $error("two-channel trim not taken from its register");

   chk_one_mode_map: assert property ( // R02
      state_q.one_mode |-> (trim_a_bank0 == state_q.regs[IDX_A0_ONE][GAIN_MSB:GAIN_LSB]
         && trim_a_bank1 == state_q.regs[IDX_A1_ONE][GAIN_MSB:GAIN_LSB]
         && trim_b_bank0 == state_q.regs[IDX_B0_ONE][GAIN_MSB:GAIN_LSB]
         && trim_b_bank1 == state_q.regs[IDX_B1_ONE][GAIN_MSB:GAIN_LSB]))
      else $error("one-channel trim not taken from its register");

   chk_two_a0_pass: assert property ( // R01
      !one_channel_mode |=> (trim_a_bank0 == $past(trim_a_bank0_two_channel)))
      else $error("two-channel a0 trim not taken from its input");

   // register port: storage of the written bytes
   chk_reserved_bits_rw: assert property ( // R03
      (reg_wr_en && hit && !fuse_ok) |=> state_q.regs[$past(idx)][RSVD_MSB:RSVD_LSB]
         == $past(reg_wdata[RSVD_MSB:RSVD_LSB]))
      else $error("reserved bits did not store written value");

   chk_write_store: assert property ( // R07
      (reg_wr_en && hit && !(fuse_ok && fuse_index == idx)) |=> state_q.regs[$past(idx)]
         == $past(reg_wdata))
      else $error("write did not update its register");

   // fuse port
   chk_fuse_two_load: assert property ( // R04
      (fuse_ok && fuse_index < IDX_A0_ONE) |=> state_q.regs[$past(fuse_index)]
         == {RSVD_RESET, $past(fuse_trim)})
      else $error("two-channel fuse trim not loaded");

   chk_fuse_one_load: assert property ( // R05
      (fuse_ok && fuse_index >= IDX_A0_ONE) |=> state_q.regs[$past(fuse_index)]
         == {RSVD_RESET, $past(fuse_trim)})
      else $error("one-channel fuse trim not loaded");

   chk_fuse_spare_index: assert property ( // R04
      (fuse_valid && !fuse_ok && !reg_wr_en) |=> $stable(state_q.regs))
      else $error("fuse strobe on the spare index changed a register");

   // reset, then register port read back, read answer and its idle level
   chk_reset_clear: assert property (@(posedge clk) disable iff (1'b0) // R06
      !rstn |=> (state_q.regs == '0 && reg_rdata == REG_RESET && !reg_rvalid))
      else $error("bank not zero after reset");

   chk_reset_trims: assert property (@(posedge clk) disable iff (1'b0) // R06
      !rstn |=> (trim_a_bank0 == '0 && trim_a_bank1 == '0
         && trim_b_bank0 == '0 && trim_b_bank1 == '0))
      else $error("trim outputs not zero after reset");

   chk_write_readback: assert property ( // R07
      (reg_wr_en && hit && !fuse_ok) ##1 (reg_rd_en && reg_addr == $past(reg_addr)
         && !reg_wr_en && !fuse_valid) |=> (reg_rvalid && reg_rdata == $past(reg_wdata, 2)))
      else $error("read did not return last write");

   chk_unmapped_read: assert property ( // R07
      (reg_rd_en && !hit) |=> (reg_rvalid && reg_rdata == UNMAPPED_READ))
      else $error("unmapped read not zero");

   chk_rvalid_pulse: assert property ( // R07
      reg_rd_en |=> reg_rvalid)
      else $error("read not answered one cycle later");

   chk_rdata_idle: assert property ( // R07
      !reg_rd_en |=> (!reg_rvalid && reg_rdata == UNMAPPED_READ))
      else $error("read answer did not return to idle");

   // main scenarios
   cov_one_mode_write: cover property (one_channel_mode && reg_wr_en && hit);
   cov_fuse_then_read: cover property (fuse_ok ##[1:4] (reg_rd_en && hit));
   cov_mode_switch: cover property (!state_q.one_mode ##1 state_q.one_mode);
   cov_back_to_back: cover property ((reg_wr_en && hit) ##1 (reg_rd_en && hit));
   cov_fuse_spare: cover property (fuse_valid && !fuse_ok);
endmodule

// ### logic/fgtrim_pkg.sv
/*
 * package of the fine gain trim bank: offsets, field layout, reset values
 * assumes a byte-wide register port that carries 16-bit addresses
 */
package fgtrim_pkg;
   // ==========================================================
   // register port shape
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int TRIM_W = 5;
   localparam int NUM_REGS = 7;
   localparam int IDX_W = 3;

   // ==========================================================
   // register offsets
   localparam logic [15:0] OFS_A1_TWO = 16'h0351;
   localparam logic [15:0] OFS_B0_TWO = 16'h0352;
   localparam logic [15:0] OFS_B1_TWO = 16'h0353;
   localparam logic [15:0] OFS_A0_ONE = 16'h0354;
   localparam logic [15:0] OFS_A1_ONE = 16'h0355;
   localparam logic [15:0] OFS_B0_ONE = 16'h0356;
   localparam logic [15:0] OFS_B1_ONE = 16'h0357;

   // ==========================================================
   // register index in the bank, offset minus the first offset
   localparam logic [2:0] IDX_A1_TWO = 3'h0;
   localparam logic [2:0] IDX_B0_TWO = 3'h1;
   localparam logic [2:0] IDX_B1_TWO = 3'h2;
   localparam logic [2:0] IDX_A0_ONE = 3'h3;
   localparam logic [2:0] IDX_A1_ONE = 3'h4;
   localparam logic [2:0] IDX_B0_ONE = 3'h5;
   localparam logic [2:0] IDX_B1_ONE = 3'h6;

   // ==========================================================
   // field layout and reset values
   localparam int GAIN_LSB = 0;
   localparam int GAIN_MSB = 4;
   localparam int RSVD_LSB = 5;
   localparam int RSVD_MSB = 7;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [4:0] GAIN_RESET = 5'h00;
   localparam logic [2:0] RSVD_RESET = 3'h0;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// ### test/fgtrim_bank_tb_top.sv
/*
 * self-checking bench of the fine gain trim bank: reset, write, read, fuse, mode steering
 * assumes the bank carries its own assertions and the package fgtrim_pkg is compiled first
 */
`timescale 1ns/1ps
module fgtrim_bank_tb_top;
   import fgtrim_pkg::*;
   // ==========================================================
   // stimulus and observation
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic fuse_valid = 1'b0;
   logic [2:0] fuse_index = 3'h0;
   logic [4:0] fuse_trim = 5'h00;
   logic one_channel_mode = 1'b0;
   logic [4:0] a0_two = 5'h15;
   logic [4:0] ta0, ta1, tb0, tb1;
   logic [7:0] wv [7];
   int bad_count = 0;
   int n_checks = 0;
   // free-running 100 MHz clock
   always #5 clk = ~clk;
   fgtrim_bank dut (.clk(clk), .rstn(rstn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .fuse_valid(fuse_valid), .fuse_index(fuse_index),
      .fuse_trim(fuse_trim), .one_channel_mode(one_channel_mode),
      .trim_a_bank0_two_channel(a0_two), .trim_a_bank0(ta0), .trim_a_bank1(ta1),
      .trim_b_bank0(tb0), .trim_b_bank1(tb1));
   // ==========================================================
   // comparison, verdict and access tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr_en <= 1'b0;
   endtask
   // read answer is awaited for a few cycles at most
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      int k;
      @(posedge clk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      #1;
      for (k = 0; k < 4 && reg_rvalid !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      if (reg_rvalid !== 1'b1) begin
         bad_count++;
         report_and_stop();
      end else begin
         chk(reg_rdata, e);
      end
   endtask
   task automatic fz(input logic [2:0] i, input logic [4:0] t);
      @(posedge clk);
      fuse_valid <= 1'b1;
      fuse_index <= i;
      fuse_trim <= t;
      @(posedge clk);
      fuse_valid <= 1'b0;
   endtask
   // write, then read the same register at the very next edge
   task automatic wr_rd(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b1;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      #1;
      chk({7'h00, reg_rvalid}, 8'h01);
      chk(reg_rdata, d);
   endtask
   // reset held for two edges in mid-run
   task automatic pulse_reset();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
   endtask
   // sets the mode, lets one edge land, then compares all four trims
   task automatic trims(input logic m, input logic [7:0] e0, e1, e2, e3);
      @(posedge clk);
      one_channel_mode <= m;
      @(posedge clk);
      #1;
      chk({3'h0, ta0}, e0);
      chk({3'h0, ta1}, e1);
      chk({3'h0, tb0}, e2);
      chk({3'h0, tb1}, e3);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rd(OFS_A1_TWO + 16'(i), REG_RESET);
         wv[i] = {3'(7 - i), 5'(4 * i + 3)};
      end
      trims(1'b1, 8'h00, 8'h00, 8'h00, 8'h00);
      for (int i = 0; i < 7; i++) begin
         wr(OFS_A1_TWO + 16'(i), wv[i]);
      end
      wr(16'h0358, 8'hFF);
      rd(16'h0350, UNMAPPED_READ);
      for (int i = 0; i < 7; i++) begin
         rd(OFS_A1_TWO + 16'(i), wv[i]);
      end
      trims(1'b0, 8'h15, {3'h0, wv[0][4:0]}, {3'h0, wv[1][4:0]}, {3'h0, wv[2][4:0]});
      trims(1'b1, {3'h0, wv[3][4:0]}, {3'h0, wv[4][4:0]}, {3'h0, wv[5][4:0]},
         {3'h0, wv[6][4:0]});
      wr_rd(OFS_A1_ONE, 8'hA5);
      // factory loads clear the reserved bits; index 7 must change nothing
      for (int i = 0; i < 7; i++) begin
         fz(3'(i), 5'(5'h1F - i));
      end
      fz(3'h7, 5'h00);
      for (int i = 0; i < 7; i++) begin
         rd(OFS_A1_TWO + 16'(i), {3'h0, 5'(5'h1F - i)});
      end
      trims(1'b1, 8'h1C, 8'h1B, 8'h1A, 8'h19);
      a0_two <= 5'h0A;
      trims(1'b0, 8'h0A, 8'h1F, 8'h1E, 8'h1D);
      // reset in mid-run clears the whole bank and the trims again
      pulse_reset();
      for (int i = 0; i < 7; i++) begin
         rd(OFS_A1_TWO + 16'(i), REG_RESET);
      end
      trims(1'b1, 8'h00, 8'h00, 8'h00, 8'h00);
      report_and_stop();
   end
endmodule
